/* File: src/pxcal_regs.vh */
// Purpose: Register offsets, field positions and timing figures of the proximity calibration block
// Assumes: APB byte addresses are four times the register index
// Notes:   Definitions only
`ifndef PXCAL_REGS_VH
`define PXCAL_REGS_VH

// Register indices and byte addresses
`define PXCAL_IDX_HOLD_SKIP     12'h002
`define PXCAL_IDX_THRESH        12'h003
`define PXCAL_IDX_RECAL         12'h004
`define PXCAL_IDX_MODE          12'h000
`define PXCAL_IDX_STATUS        12'h005
`define PXCAL_ADDR_HOLD_SKIP    12'h008
`define PXCAL_ADDR_THRESH       12'h00c
`define PXCAL_ADDR_RECAL        12'h010
`define PXCAL_ADDR_MODE         12'h000
`define PXCAL_ADDR_STATUS       12'h014

// Field positions
`define PXCAL_SKIP_LSB          0
`define PXCAL_FP_HOLD_LSB       4
`define PXCAL_LP_HOLD_LSB       8
`define PXCAL_LEVEL_LSB         0
`define PXCAL_RATE_LSB          8
`define PXCAL_FP_RECAL_LSB      0
`define PXCAL_LP_RECAL_LSB      10
`define PXCAL_MODE_LP_BIT       0
`define PXCAL_SLEEP_LSB         2

// Reset values
`define PXCAL_RST_HOLD_SKIP     16'h0000
`define PXCAL_RST_THRESH        16'h0000
`define PXCAL_RST_RECAL         16'h0000
`define PXCAL_RST_MODE          16'h0000

// Multipliers
`define PXCAL_FP_HOLD_MULT      16
`define PXCAL_LP_HOLD_MULT      4
`define PXCAL_LSB_SCALE_SHIFT   4

// Low power inter-sequence delay unit, in ms, and clock rate in kHz
`define PXCAL_SLEEP_UNIT_MS     200
`define PXCAL_CLK_KHZ           40000
`define PXCAL_SLEEP_UNIT_CYC    (`PXCAL_SLEEP_UNIT_MS * `PXCAL_CLK_KHZ)

`endif

/* File: src/pxcal_top.v */
// Purpose: Per-stage proximity detection and ambient calibration control
// Assumes: Converter results arrive with a per-result valid strobe on pclk
// Notes:   Hold-off and recalibration times are counted in conversion sequences, marked by seq_end; sleep in pclk cycles
//
// Register access over APB was chosen for this implementation.
`include "pxcal_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pxcal_top #(
    parameter STAGES    = 12,
    parameter DW        = 16,
    parameter SLEEP_CYC = `PXCAL_SLEEP_UNIT_CYC
) (
    // APB
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // Converter results
    input  wire                conv_valid,
    input  wire [3:0]          conv_stage,
    input  wire [DW-1:0]       conv_data,
    input  wire                seq_end,
    input  wire [STAGES-1:0]   slow_update_lvl_hit,
    // Sequencer control
    output reg                 conv_start,
    // Per-stage results
    output reg  [STAGES-1:0]   proximity,
    output reg  [STAGES-1:0]   cal_enable,
    output reg  [STAGES-1:0]   slow_queue_take,
    output reg  [STAGES-1:0]   force_recal
);

    // ********************************
    // Register file
    // ********************************
    reg [15:0] hold_skip_reg;
    reg [15:0] thresh_reg;
    reg [15:0] recal_reg;
    reg [15:0] mode_reg;

    wire [3:0] fast_queue_skip_count      = hold_skip_reg[`PXCAL_SKIP_LSB +: 4];
    wire [3:0] full_power_cal_hold_count  = hold_skip_reg[`PXCAL_FP_HOLD_LSB +: 4];
    wire [3:0] low_power_cal_hold_count   = hold_skip_reg[`PXCAL_LP_HOLD_LSB +: 4];
    wire [7:0] hover_compare_level        = thresh_reg[`PXCAL_LEVEL_LSB +: 8];
    wire [5:0] detect_rate                = thresh_reg[`PXCAL_RATE_LSB +: 6];
    wire [9:0] full_power_recal_timeout   = recal_reg[`PXCAL_FP_RECAL_LSB +: 10];
    wire [5:0] low_power_recal_timeout    = recal_reg[`PXCAL_LP_RECAL_LSB +: 6];
    wire       low_power                  = mode_reg[`PXCAL_MODE_LP_BIT];
    wire [1:0] sleep_interval_select      = mode_reg[`PXCAL_SLEEP_LSB +: 2];

    // Hold-off length in sequences, per mode
    wire [9:0] hold_len = low_power ?
        {4'h0, low_power_cal_hold_count, 2'b00} :
        {2'h0, full_power_cal_hold_count, 4'h0};
    wire [9:0] recal_len = low_power ? {4'h0, low_power_recal_timeout}
                                     : full_power_recal_timeout;

    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pwrite & pready;

    // ********************************
    // Register writes
    // ********************************
    // A write lands only in the access cycle that pready closes
    wire wr_hold_skip = apb_wr && (paddr == `PXCAL_ADDR_HOLD_SKIP);
    wire wr_thresh    = apb_wr && (paddr == `PXCAL_ADDR_THRESH);
    wire wr_recal     = apb_wr && (paddr == `PXCAL_ADDR_RECAL);
    wire wr_mode      = apb_wr && (paddr == `PXCAL_ADDR_MODE);

    // Unused upper bits are stored as zero so that they read back as zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_skip_reg <= `PXCAL_RST_HOLD_SKIP;
            thresh_reg    <= `PXCAL_RST_THRESH;
            recal_reg     <= `PXCAL_RST_RECAL;
            mode_reg      <= `PXCAL_RST_MODE;
        end else begin
            if (wr_hold_skip) begin
                hold_skip_reg <= {4'h0, pwdata[11:0]};
            end
            if (wr_thresh) begin
                thresh_reg <= {2'b00, pwdata[13:0]};
            end
            if (wr_recal) begin
                recal_reg <= pwdata[15:0];
            end
            if (wr_mode) begin
                mode_reg <= {12'h000, pwdata[3:2], 1'b0, pwdata[0]};
            end
        end
    end

    // ********************************
    // APB answer
    // ********************************
    // Decode is combinational; the answer is registered in the setup cycle
    // so that pready, prdata and pslverr stand together for one cycle
    reg [31:0] rd_data_next;
    reg        rd_err_next;

    always @* begin
        rd_data_next = 32'h0000_0000;
        rd_err_next  = 1'b0;
        case (paddr)
        `PXCAL_ADDR_HOLD_SKIP: rd_data_next = {16'h0000, hold_skip_reg};
        `PXCAL_ADDR_THRESH:    rd_data_next = {16'h0000, thresh_reg};
        `PXCAL_ADDR_RECAL:     rd_data_next = {16'h0000, recal_reg};
        `PXCAL_ADDR_MODE:      rd_data_next = {16'h0000, mode_reg};
        `PXCAL_ADDR_STATUS:    rd_data_next = {16'h0000, 4'h0, proximity};
        default:               rd_err_next  = 1'b1;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            // No wait state: answer comes in the first access cycle
            pready  <= apb_setup;
            pslverr <= apb_setup & rd_err_next;
            if (apb_setup) begin
                prdata <= rd_data_next;
            end
        end
    end

    // ********************************
    // Sequence pacing
    // ********************************
    // In low power the next sequence waits (select+1) sleep units after the last one ends;
    // counting from the end of a sequence makes the period conversion time plus sleep
    localparam [0:0] PACE_RUN   = 1'b0;
    localparam [0:0] PACE_SLEEP = 1'b1;

    reg  [0:0]  pace_state_reg;
    reg  [0:0]  pace_state_next;
    reg  [31:0] sleep_cnt_reg;
    reg  [31:0] sleep_cnt_next;
    reg         conv_start_next;
    wire [31:0] sleep_len = SLEEP_CYC * ({30'h0, sleep_interval_select} + 32'h1);

    always @* begin
        pace_state_next = pace_state_reg;
        sleep_cnt_next  = sleep_cnt_reg;
        conv_start_next = 1'b0;
        if (seq_end) begin
            if (low_power) begin
                pace_state_next = PACE_SLEEP;
                sleep_cnt_next  = 32'h0000_0000;
            end else begin
                conv_start_next = 1'b1;
            end
        end else begin
            case (pace_state_reg)
            PACE_RUN:   pace_state_next = PACE_RUN;
            PACE_SLEEP: begin
                if (sleep_cnt_reg >= sleep_len - 32'h1) begin
                    pace_state_next = PACE_RUN;
                    conv_start_next = 1'b1;
                end else begin
                    sleep_cnt_next = sleep_cnt_reg + 32'h1;
                end
            end
            default:    pace_state_next = PACE_RUN;
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_state_reg <= PACE_RUN;
            sleep_cnt_reg  <= 32'h0000_0000;
            conv_start     <= 1'b0;
        end else begin
            pace_state_reg <= pace_state_next;
            sleep_cnt_reg  <= sleep_cnt_next;
            conv_start     <= conv_start_next;
        end
    end

    // ********************************
    // Fast queue pick
    // ********************************
    // Skip counter: fast queue takes one sequence out of skip+1
    reg  [3:0] skip_cnt_reg;
    reg        fq_take_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_cnt_reg <= 4'h0;
            fq_take_reg  <= 1'b1;
        end else if (seq_end) begin
            if (skip_cnt_reg >= fast_queue_skip_count) begin
                skip_cnt_reg <= 4'h0;
                fq_take_reg  <= 1'b1;
            end else begin
                skip_cnt_reg <= skip_cnt_reg + 4'h1;
                fq_take_reg  <= 1'b0;
            end
        end
    end

    // ********************************
    // Per-stage proximity and calibration control
    // ********************************
    genvar s;
    generate
        for (s = 0; s < STAGES; s = s + 1) begin : g_stage
            localparam [3:0] STAGE_ID = s;

            reg  [DW-1:0] fq_reg [0:3];
            reg  [DW-1:0] ambient_reg;
            reg  [DW-1:0] ambient_next;
            reg  [9:0]    hold_cnt_reg;
            reg  [9:0]    hold_cnt_next;
            reg           holding_reg;
            reg           holding_next;
            reg           cal_next;
            reg  [9:0]    recal_cnt_reg;
            reg  [9:0]    recal_cnt_next;
            reg           recal_fire;
            reg           take_now;
            wire          hit = conv_valid && (conv_stage == STAGE_ID);

            // Comparators read the queue as it stands, so a new sample
            // reaches the proximity flag two cycles after its strobe
            wire [DW+1:0] fq_sum = {2'b00, fq_reg[0]} + {2'b00, fq_reg[1]}
                                 + {2'b00, fq_reg[2]} + {2'b00, fq_reg[3]};
            wire [DW-1:0] fq_avg = fq_sum[DW+1:2];
            wire [DW-1:0] d13 = (fq_reg[1] > fq_reg[3]) ? fq_reg[1] - fq_reg[3]
                                                        : fq_reg[3] - fq_reg[1];
            wire [DW-1:0] dav = (fq_avg > ambient_reg) ? fq_avg - ambient_reg
                                                       : ambient_reg - fq_avg;
            wire [DW+3:0] rate_lim  = {{(DW-6){1'b0}}, detect_rate, 4'h0};
            wire [DW+3:0] level_lim = {{(DW-8){1'b0}}, hover_compare_level, 4'h0};
            wire cmp1 = {4'h0, d13} > rate_lim;
            wire cmp2 = {4'h0, dav} > level_lim;
            wire prox_now = cmp1 | cmp2;

            // ****************************
            // Fast queue, word 0 newest
            // ****************************
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fq_reg[0] <= {DW{1'b0}};
                    fq_reg[1] <= {DW{1'b0}};
                    fq_reg[2] <= {DW{1'b0}};
                    fq_reg[3] <= {DW{1'b0}};
                end else if (hit && fq_take_reg) begin
                    fq_reg[0] <= conv_data;
                    fq_reg[1] <= fq_reg[0];
                    fq_reg[2] <= fq_reg[1];
                    fq_reg[3] <= fq_reg[2];
                end
            end

            // ****************************
            // Calibration gate and hold-off
            // ****************************
            // The counter restarts from zero only while proximity is present
            always @* begin
                holding_next  = holding_reg;
                hold_cnt_next = hold_cnt_reg;
                cal_next      = cal_enable[s];
                if (prox_now) begin
                    cal_next      = 1'b0;
                    holding_next  = 1'b1;
                    hold_cnt_next = 10'h000;
                end else if (holding_reg) begin
                    if (hold_cnt_reg >= hold_len) begin
                        holding_next = 1'b0;
                        cal_next     = 1'b1;
                    end else if (seq_end) begin
                        hold_cnt_next = hold_cnt_reg + 10'h001;
                    end
                end else begin
                    cal_next = 1'b1;
                end
            end

            // ****************************
            // Forced recalibration
            // ****************************
            always @* begin
                recal_cnt_next = recal_cnt_reg;
                recal_fire     = 1'b0;
                if (!cmp2) begin
                    recal_cnt_next = 10'h000;
                end else if (seq_end) begin
                    if (recal_cnt_reg + 10'h001 >= recal_len) begin
                        recal_fire     = 1'b1;
                        recal_cnt_next = 10'h000;
                    end else begin
                        recal_cnt_next = recal_cnt_reg + 10'h001;
                    end
                end
            end

            // ****************************
            // Ambient value
            // ****************************
            // A take needs proximity clear and a forced load needs comparator two,
            // so the two sources never meet in one cycle
            always @* begin
                take_now     = hit && slow_update_lvl_hit[s] && !prox_now && !holding_reg;
                ambient_next = ambient_reg;
                if (recal_fire) begin
                    ambient_next = fq_avg;
                end else if (take_now) begin
                    ambient_next = conv_data;
                end
            end

            // ****************************
            // Stage state and outputs
            // ****************************
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ambient_reg        <= {DW{1'b0}};
                    hold_cnt_reg       <= 10'h000;
                    holding_reg        <= 1'b0;
                    recal_cnt_reg      <= 10'h000;
                    proximity[s]       <= 1'b0;
                    cal_enable[s]      <= 1'b1;
                    slow_queue_take[s] <= 1'b0;
                    force_recal[s]     <= 1'b0;
                end else begin
                    ambient_reg        <= ambient_next;
                    hold_cnt_reg       <= hold_cnt_next;
                    holding_reg        <= holding_next;
                    recal_cnt_reg      <= recal_cnt_next;
                    proximity[s]       <= prox_now;
                    cal_enable[s]      <= cal_next;
                    slow_queue_take[s] <= take_now;
                    force_recal[s]     <= recal_fire;
                end
            end
        end
    endgenerate

endmodule // pxcal_top

`default_nettype wire

/* File: testbench/pxcal_sva.sv */
// Purpose: Port-level checks of pxcal_top
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Low power mode bit is mirrored from APB writes to offset 0x000
`timescale 1ns/1ps
`default_nettype none
module pxcal_sva #(
    parameter STAGES = 12
) (
    // APB
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Converter and per-stage results
    input wire logic              seq_end,
    input wire logic              conv_start,
    input wire logic [STAGES-1:0] slow_update_lvl_hit,
    input wire logic [STAGES-1:0] proximity,
    input wire logic [STAGES-1:0] cal_enable,
    input wire logic [STAGES-1:0] slow_queue_take,
    input wire logic [STAGES-1:0] force_recal
);
    // ****************************************
    // Mode mirror and properties
    // ****************************************
    logic       lp_reg;
    logic [3:0] fp_hold_reg;
    logic [3:0] lp_hold_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lp_reg      <= 1'b0;
            fp_hold_reg <= 4'h0;
            lp_hold_reg <= 4'h0;
        end else if (psel && penable && pready && pwrite) begin
            if (paddr == 12'h000)
                lp_reg <= pwdata[0];
            if (paddr == 12'h008) begin
                fp_hold_reg <= pwdata[7:4];
                lp_hold_reg <= pwdata[11:8];
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence one_ready;
        pready ##1 !pready;
    endsequence
    apb_answer_a: assert property (apb_setup |=> one_ready)
        else $error("ready not a single cycle after setup");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && !pwrite && paddr > 12'h014
        |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    fp_restart_a: assert property (!lp_reg && seq_end |=> conv_start)
        else $error("no restart after sequence");
    prox_freeze_a: assert property ($rose(proximity[0]) |-> !cal_enable[0])
        else $error("calibration runs at proximity");
    prox_hold_a: assert property (proximity[0] && $past(proximity[0])
        |-> !cal_enable[0] && !slow_queue_take[0]) else $error("calibration during proximity");
    hold_start_a: assert property ($fell(proximity[0])
        && ((lp_reg ? lp_hold_reg : fp_hold_reg) != 4'h0) |-> !cal_enable[0])
        else $error("no hold-off after proximity");
    take_cause_a: assert property (slow_queue_take[0] |-> $past(slow_update_lvl_hit[0]))
        else $error("slow queue take without update level");
    recal_pulse_a: assert property (force_recal[0] |-> proximity[0] ##1 !force_recal[0])
        else $error("forced recalibration malformed");
endmodule // pxcal_sva
bind pxcal_top pxcal_sva #(.STAGES(STAGES)) i_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .seq_end, .conv_start, .slow_update_lvl_hit,
    .proximity, .cal_enable, .slow_queue_take, .force_recal);
`default_nettype wire

/* File: testbench/pxcal_conv_model.sv */
// Purpose: Converter model producing twelve stage results and a sequence end
// Assumes: A sequence starts on conv_start or a bench kick while idle
// Notes:   Stage 0 carries the bench value, other stages a quiet level
`timescale 1ns/1ps
`default_nettype none
module pxcal_conv_model (
    // Clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // Bench control
    input wire logic         kick,
    input wire logic         slow,
    input wire logic [15:0]  val,
    // Design side
    input wire logic         conv_start,
    output logic             conv_valid,
    output logic [3:0]       conv_stage,
    output logic [15:0]      conv_data,
    output logic             seq_end
);
    // ****************************************
    // Sequence engine
    // ****************************************
    logic       busy;
    logic       gap;
    logic [4:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy, gap, cnt, conv_valid, conv_stage, conv_data, seq_end} <= '0;
        end else begin
            conv_valid <= 1'b0;
            seq_end <= 1'b0;
            // Data is not held past its strobe
            conv_data <= ~conv_data;
            if (!busy)
                busy <= kick || conv_start;
            else if (gap)
                gap <= 1'b0;
            else if (cnt == 5'd12) begin
                busy <= 1'b0;
                cnt <= 5'd0;
                seq_end <= 1'b1;
            end else begin
                conv_valid <= 1'b1;
                conv_stage <= cnt[3:0];
                conv_data <= (cnt == 5'd0) ? val : 16'h0100;
                cnt <= cnt + 5'd1;
                gap <= slow;
            end
        end
    end
endmodule // pxcal_conv_model
`default_nettype wire

/* File: testbench/pxcal_top_tb.sv */
// Purpose: Self-checking bench for pxcal_top
// Assumes: SLEEP_CYC shortened to 20 cycles
// Notes:   Hold-off and recalibration times are counted in sequence end pulses, sleep in clock cycles
`include "pxcal_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module pxcal_top_tb;
    // ****************************************
    // Stimulus, design and tasks
    // ****************************************
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, kick = 0, slow = 0;
    logic [11:0] paddr = 0, slow_update_lvl_hit = 0, proximity, cal_enable;
    logic [11:0] slow_queue_take, force_recal;
    logic [31:0] pwdata = 0, prdata, r;
    logic [15:0] val = 16'h03e8, conv_data;
    logic [3:0]  conv_stage;
    logic        pready, pslverr, conv_valid, seq_end, conv_start, e;
    int          fails = 0, checked = 0, n, cyc, takes = 0;
    logic [11:0] ad [3] = '{`PXCAL_ADDR_HOLD_SKIP, `PXCAL_ADDR_THRESH, `PXCAL_ADDR_RECAL};
    logic [31:0] mk [3] = '{32'h0fff, 32'h3fff, 32'hffff};
    initial forever #12.5 pclk = ~pclk;
    pxcal_top #(.SLEEP_CYC(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .conv_valid, .conv_stage, .conv_data, .seq_end,
        .slow_update_lvl_hit, .conv_start, .proximity, .cal_enable, .slow_queue_take,
        .force_recal);
    pxcal_conv_model i_conv (.pclk, .presetn, .kick, .slow, .val, .conv_start, .conv_valid,
        .conv_stage, .conv_data, .seq_end);
    always @(posedge pclk) if (slow_queue_take[0] === 1'b1) takes++;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin fails++; conclude; end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // Counts sequence ends until the chosen condition holds
    task wait_on(input int which);
        logic [5:0] c;
        n = 0;
        for (cyc = 0; cyc < 5000; cyc++) begin
            @(posedge pclk);
            #1;
            c = {conv_start, seq_end, !proximity[0], proximity[0], cal_enable[0], force_recal[0]};
            if (c[which] === 1'b1) break;
            if (seq_end === 1'b1) n++;
        end
        if (cyc == 5000) begin fails++; conclude; end
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(0, ad[i], 0);
            chk(r, 0);
            apb(1, ad[i], 32'hffffffff);
            apb(0, ad[i], 0);
            chk(r, mk[i]);
        end
        apb(0, 12'h0fc, 0);
        chk({r[30:0], e}, 1);
        apb(1, ad[0], 32'h0210);
        apb(1, ad[1], 32'h3f32);
        apb(1, ad[2], 32'hfc03);
        kick <= 1'b1;
        @(posedge pclk);
        kick <= 1'b0;
        wait_on(2);
        chk(cal_enable[0], 0);
        wait_on(0);
        chk(n, 3);
        chk(proximity[0], 1);
        wait_on(1);
        chk(n, 16);
        apb(1, `PXCAL_ADDR_MODE, 1);
        slow <= 1'b1;
        val <= 16'h0bb8;
        wait_on(2);
        apb(0, `PXCAL_ADDR_STATUS, 0);
        chk(r, 1);
        val <= 16'h03e8;
        wait_on(3);
        wait_on(1);
        chk(n, 8);
        slow_update_lvl_hit <= 12'hfff;
        for (int c = 0; c < 4; c++) begin
            apb(1, `PXCAL_ADDR_MODE, 32'h1 | (c << 2));
            wait_on(4);
            wait_on(5);
            chk(32'(cyc >= 20 * (c + 1) - 1 && cyc <= 20 * (c + 1) + 3), 1);
        end
        chk(32'(takes > 0), 1);
        conclude;
    end
endmodule // pxcal_top_tb
`default_nettype wire
